/* verilog/urd_pkg.sv */
package urd_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] URD_IDX_RX_TX_DIVLO = 16'h9c00;
	localparam logic [15:0] URD_IDX_IER_DIVHI = 16'h9c01;
	localparam logic [15:0] URD_IDX_IIR_FCR = 16'h9c02;
	localparam logic [15:0] URD_IDX_LINE_CTRL = 16'h9c03;
	localparam logic [15:0] URD_IDX_MODEM_CTRL = 16'h9c04;
	localparam logic [15:0] URD_IDX_LINE_STATUS = 16'h9c05;
	localparam logic [15:0] URD_IDX_SCRATCH = 16'h9c07;
	localparam logic [15:0] URD_IDX_DIVLO_DIRECT = 16'h9c08;
	localparam logic [15:0] URD_IDX_DIVHI_DIRECT = 16'h9c09;
	localparam logic [15:0] URD_IDX_PID_LOW = 16'h9c0a;
	localparam logic [15:0] URD_IDX_PID_HIGH = 16'h9c0b;
	localparam logic [15:0] URD_IDX_PWR_EMU = 16'h9c0c;

	// Width of the word address that is compared against an index.
	localparam int URD_WORD_ADDR_W = 30;

	// Field positions.
	localparam int URD_LCR_DIV_ACCESS_BIT = 7;
	localparam int URD_LSR_DATA_READY_BIT = 0;
	localparam int URD_LSR_OVERRUN_BIT = 1;
	localparam int URD_LSR_HOLD_EMPTY_BIT = 5;
	localparam int URD_LSR_TX_EMPTY_BIT = 6;
	localparam int URD_IER_RX_BIT = 0;
	localparam int URD_IER_TX_BIT = 1;
	localparam int URD_IER_LINE_BIT = 2;

	// Reset values.
	localparam logic [7:0] URD_RST_IER = 8'h00;
	localparam logic [7:0] URD_RST_IIR = 8'h01;
	localparam logic [7:0] URD_RST_FCR = 8'h00;
	localparam logic [7:0] URD_RST_LCR = 8'h00;
	localparam logic [7:0] URD_RST_MCR = 8'h00;
	localparam logic [7:0] URD_RST_LSR = 8'h60;
	localparam logic [7:0] URD_RST_SCRATCH = 8'h00;
	localparam logic [7:0] URD_RST_DIV = 8'h00;
	localparam logic [7:0] URD_RST_RX = 8'h00;
	localparam logic [15:0] URD_RST_PWR_EMU = 16'h0000;

	// Identification codes answered by the two peripheral ID registers.
	localparam logic [15:0] URD_PID_LOW_VALUE = 16'h1234; // Value is arbitrary.
	localparam logic [15:0] URD_PID_HIGH_VALUE = 16'h0001; // Value is arbitrary.

	// Interrupt identification codes, highest priority first.
	localparam logic [7:0] URD_IIR_LINE = 8'h06;
	localparam logic [7:0] URD_IIR_RX = 8'h04;
	localparam logic [7:0] URD_IIR_TX = 8'h02;

	// AHB-Lite encodings.
	localparam logic [1:0] URD_HTRANS_NONSEQ = 2'h2;
	localparam logic URD_HRESP_OKAY = 1'h0;

endpackage

/* verilog/urd_uart_regs.sv */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Flag clear: the first shared word reads rx buffer and writes tx holding.
// - Flag set: reads and writes at the first shared word reach the divisor low byte.
// - The divisor low byte also has its own word address, whatever the flag holds.
// - Second shared word: irq enable if the flag is clear, divisor high byte if set.
// - The divisor high byte also has its own word address, whatever the flag holds.
// - Third shared word: reads give irq identification, writes load FIFO control only.
module urd_uart_regs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic tx_taken,
	input wire logic tx_idle,
	output logic [7:0] tx_holding,
	output logic tx_load,
	output logic [15:0] divisor,
	output logic [7:0] irq_enable,
	output logic [7:0] line_ctrl,
	output logic [7:0] modem_ctrl,
	output logic [7:0] fifo_ctrl,
	output logic fifo_ctrl_load,
	output logic [15:0] power_emu_ctrl,
	output logic irq_pending
);

	logic wr_pend_q;
	logic [15:0] wr_idx_q;
	logic rd_pend_q;
	logic [15:0] rd_idx_q;
	logic [31:0] hrdata_q;
	logic addr_ok;
	logic [15:0] addr_idx;
	logic take;
	logic div_access;
	logic [7:0] wdata;
	logic [7:0] rx_buffer_q;
	logic [7:0] tx_holding_q;
	logic tx_load_q;
	logic [7:0] divisor_low_q;
	logic [7:0] divisor_high_q;
	logic [7:0] irq_enable_reg_q;
	logic [7:0] fifo_ctrl_reg_q;
	logic fifo_ctrl_load_q;
	logic [7:0] line_ctrl_reg_q;
	logic [7:0] modem_ctrl_q;
	logic [7:0] scratch_q;
	logic [15:0] power_emu_q;
	logic data_ready_q;
	logic overrun_q;
	logic hold_empty_q;
	logic [7:0] line_status;
	logic [7:0] irq_ident_reg;
	logic wr_txh;
	logic wr_divlo;
	logic wr_divhi;
	logic wr_ier;
	logic wr_fcr;
	logic rd_rxb;
	logic rd_lsr;
	logic [31:0] rd_mux;

	// Only the low 16 bits of the word address carry an index; all upper bits must be zero.
	assign addr_idx = haddr[17:2];
	assign addr_ok = haddr[31:18] == 14'h0000;
	assign take = hsel && hready && htrans == urd_pkg::URD_HTRANS_NONSEQ;

	assign div_access = line_ctrl_reg_q[urd_pkg::URD_LCR_DIV_ACCESS_BIT];
	assign wdata = hwdata[7:0];

	// Reads wait one cycle so that a write just before them is already visible.
	assign hreadyout = !rd_pend_q;
	assign hresp = urd_pkg::URD_HRESP_OKAY;
	assign hrdata = hrdata_q;

	// Address phase capture.
	// A write never waits, so its data phase always closes on the next edge.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 16'h0000;
		end else if (hready) begin
			wr_pend_q <= take && hwrite && addr_ok;
			wr_idx_q <= addr_idx;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_pend_q <= 1'b0;
			rd_idx_q <= 16'h0000;
		end else if (rd_pend_q) begin
			rd_pend_q <= 1'b0;
		end else if (take && !hwrite) begin
			rd_pend_q <= 1'b1;
			rd_idx_q <= addr_ok ? addr_idx : 16'h0000;
		end
	end

	// Write strobes for the data phase, steered by the divisor-access flag.
	always_comb begin
		wr_txh = 1'b0;
		wr_divlo = 1'b0;
		wr_divhi = 1'b0;
		wr_ier = 1'b0;
		wr_fcr = 1'b0;
		if (wr_pend_q) begin
			case (wr_idx_q)
				urd_pkg::URD_IDX_RX_TX_DIVLO: begin
					wr_txh = !div_access;
					wr_divlo = div_access;
				end
				urd_pkg::URD_IDX_IER_DIVHI: begin
					wr_ier = !div_access;
					wr_divhi = div_access;
				end
				urd_pkg::URD_IDX_IIR_FCR: begin
					wr_fcr = 1'b1;
				end
				urd_pkg::URD_IDX_DIVLO_DIRECT: begin
					wr_divlo = 1'b1;
				end
				urd_pkg::URD_IDX_DIVHI_DIRECT: begin
					wr_divhi = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Read side effects happen on the cycle the read data is latched.
	assign rd_rxb = rd_pend_q && rd_idx_q == urd_pkg::URD_IDX_RX_TX_DIVLO && !div_access;
	assign rd_lsr = rd_pend_q && rd_idx_q == urd_pkg::URD_IDX_LINE_STATUS;

	// Transmit holding register and its load pulse to the serializer.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_holding_q <= urd_pkg::URD_RST_RX;
			tx_load_q <= 1'b0;
		end else begin
			tx_load_q <= wr_txh;
			if (wr_txh) begin
				tx_holding_q <= wdata;
			end
		end
	end

	// One storage for each divisor byte, shared by both of its addresses.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			divisor_low_q <= urd_pkg::URD_RST_DIV;
			divisor_high_q <= urd_pkg::URD_RST_DIV;
		end else begin
			if (wr_divlo) begin
				divisor_low_q <= wdata;
			end
			if (wr_divhi) begin
				divisor_high_q <= wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_enable_reg_q <= urd_pkg::URD_RST_IER;
		end else if (wr_ier) begin
			irq_enable_reg_q <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fifo_ctrl_reg_q <= urd_pkg::URD_RST_FCR;
			fifo_ctrl_load_q <= 1'b0;
		end else begin
			fifo_ctrl_load_q <= wr_fcr;
			if (wr_fcr) begin
				fifo_ctrl_reg_q <= wdata;
			end
		end
	end

	// Plain read/write registers.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			line_ctrl_reg_q <= urd_pkg::URD_RST_LCR;
			modem_ctrl_q <= urd_pkg::URD_RST_MCR;
			scratch_q <= urd_pkg::URD_RST_SCRATCH;
			power_emu_q <= urd_pkg::URD_RST_PWR_EMU;
		end else if (wr_pend_q) begin
			case (wr_idx_q)
				urd_pkg::URD_IDX_LINE_CTRL: begin
					line_ctrl_reg_q <= wdata;
				end
				urd_pkg::URD_IDX_MODEM_CTRL: begin
					modem_ctrl_q <= wdata;
				end
				urd_pkg::URD_IDX_SCRATCH: begin
					scratch_q <= wdata;
				end
				urd_pkg::URD_IDX_PWR_EMU: begin
					power_emu_q <= hwdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Receive buffer and the status flags it drives; a new byte wins over a clearing read.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_buffer_q <= urd_pkg::URD_RST_RX;
			data_ready_q <= urd_pkg::URD_RST_LSR[urd_pkg::URD_LSR_DATA_READY_BIT];
			overrun_q <= urd_pkg::URD_RST_LSR[urd_pkg::URD_LSR_OVERRUN_BIT];
		end else begin
			if (rx_valid) begin
				rx_buffer_q <= rx_data;
				data_ready_q <= 1'b1;
			end else if (rd_rxb) begin
				data_ready_q <= 1'b0;
			end
			if (rx_valid && data_ready_q && !rd_rxb) begin
				overrun_q <= 1'b1;
			end else if (rd_lsr) begin
				overrun_q <= 1'b0;
			end
		end
	end

	// Holding register empties when the serializer takes it; a new load makes it full.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hold_empty_q <= urd_pkg::URD_RST_LSR[urd_pkg::URD_LSR_HOLD_EMPTY_BIT];
		end else if (wr_txh) begin
			hold_empty_q <= 1'b0;
		end else if (tx_taken) begin
			hold_empty_q <= 1'b1;
		end
	end

	always_comb begin
		line_status = 8'h00;
		line_status[urd_pkg::URD_LSR_DATA_READY_BIT] = data_ready_q;
		line_status[urd_pkg::URD_LSR_OVERRUN_BIT] = overrun_q;
		line_status[urd_pkg::URD_LSR_HOLD_EMPTY_BIT] = hold_empty_q;
		line_status[urd_pkg::URD_LSR_TX_EMPTY_BIT] = hold_empty_q && tx_idle;
	end

	// Interrupt identification: highest-priority enabled source, else the idle code.
	always_comb begin
		if (irq_enable_reg_q[urd_pkg::URD_IER_LINE_BIT] && overrun_q) begin
			irq_ident_reg = urd_pkg::URD_IIR_LINE;
		end else if (irq_enable_reg_q[urd_pkg::URD_IER_RX_BIT] && data_ready_q) begin
			irq_ident_reg = urd_pkg::URD_IIR_RX;
		end else if (irq_enable_reg_q[urd_pkg::URD_IER_TX_BIT] && hold_empty_q) begin
			irq_ident_reg = urd_pkg::URD_IIR_TX;
		end else begin
			irq_ident_reg = urd_pkg::URD_RST_IIR;
		end
	end

	// Read multiplexer; unmapped words read as zero.
	always_comb begin
		rd_mux = 32'h00000000;
		case (rd_idx_q)
			urd_pkg::URD_IDX_RX_TX_DIVLO: begin
				rd_mux[7:0] = div_access ? divisor_low_q : rx_buffer_q;
			end
			urd_pkg::URD_IDX_IER_DIVHI: begin
				rd_mux[7:0] = div_access ? divisor_high_q : irq_enable_reg_q;
			end
			urd_pkg::URD_IDX_IIR_FCR: begin
				rd_mux[7:0] = irq_ident_reg;
			end
			urd_pkg::URD_IDX_LINE_CTRL: begin
				rd_mux[7:0] = line_ctrl_reg_q;
			end
			urd_pkg::URD_IDX_MODEM_CTRL: begin
				rd_mux[7:0] = modem_ctrl_q;
			end
			urd_pkg::URD_IDX_LINE_STATUS: begin
				rd_mux[7:0] = line_status;
			end
			urd_pkg::URD_IDX_SCRATCH: begin
				rd_mux[7:0] = scratch_q;
			end
			urd_pkg::URD_IDX_DIVLO_DIRECT: begin
				rd_mux[7:0] = divisor_low_q;
			end
			urd_pkg::URD_IDX_DIVHI_DIRECT: begin
				rd_mux[7:0] = divisor_high_q;
			end
			urd_pkg::URD_IDX_PID_LOW: begin
				rd_mux[15:0] = urd_pkg::URD_PID_LOW_VALUE;
			end
			urd_pkg::URD_IDX_PID_HIGH: begin
				rd_mux[15:0] = urd_pkg::URD_PID_HIGH_VALUE;
			end
			urd_pkg::URD_IDX_PWR_EMU: begin
				rd_mux[15:0] = power_emu_q;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_pend_q) begin
			hrdata_q <= rd_mux;
		end
	end

	assign tx_holding = tx_holding_q;
	assign tx_load = tx_load_q;
	assign divisor = {divisor_high_q, divisor_low_q};
	assign irq_enable = irq_enable_reg_q;
	assign line_ctrl = line_ctrl_reg_q;
	assign modem_ctrl = modem_ctrl_q;
	assign fifo_ctrl = fifo_ctrl_reg_q;
	assign fifo_ctrl_load = fifo_ctrl_load_q;
	assign power_emu_ctrl = power_emu_q;
	// The idle identification code means that no enabled source is asking.
	assign irq_pending = irq_ident_reg != urd_pkg::URD_RST_IIR;

endmodule

/* sim/urd_uart_regs_checker.sv */
`timescale 1ns/1ps
module urd_uart_regs_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic [7:0] tx_holding,
	input wire logic tx_load,
	input wire logic [15:0] divisor,
	input wire logic [7:0] irq_enable,
	input wire logic [7:0] line_ctrl,
	input wire logic [7:0] fifo_ctrl,
	input wire logic fifo_ctrl_load
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [29:0] w;
	logic div_access;
	logic wr_a;
	logic tx_a;
	assign w = haddr[31:2];
	assign div_access = line_ctrl[7];
	assign wr_a = hsel && hready && htrans == 2'h2 && hwrite;
	assign tx_a = wr_a && w == 30'h9c00 && !div_access;
	sequence s_wr(logic [15:0] idx, logic ok);
		wr_a && w == {14'h0, idx} && ok ##1 hready;
	endsequence
	sequence s_rd(logic [15:0] idx);
		hsel && hready && htrans == 2'h2 && !hwrite && w == {14'h0, idx};
	endsequence
	chk_tx_write: assert property (s_wr(16'h9c00, !div_access)
		|=> tx_load && tx_holding == $past(hwdata[7:0]))
		else $error("tx holding write lost");
	chk_tx_cause: assert property (tx_load |-> $past(tx_a, 2))
		else $error("tx load without tx write");
	chk_div_shared: assert property (s_wr(16'h9c00, div_access)
		|=> !tx_load && divisor[7:0] == $past(hwdata[7:0]))
		else $error("shared divisor low write lost");
	chk_div_direct: assert property (s_wr(16'h9c08, 1'b1)
		|=> divisor[7:0] == $past(hwdata[7:0]))
		else $error("direct divisor low write lost");
	chk_div_high: assert property ((s_wr(16'h9c01, div_access)
		or s_wr(16'h9c09, 1'b1)) |=> divisor[15:8] == $past(hwdata[7:0]))
		else $error("divisor high write lost");
	chk_ier_write: assert property (s_wr(16'h9c01, !div_access)
		|=> irq_enable == $past(hwdata[7:0]) && $stable(divisor))
		else $error("irq enable write wrong");
	chk_fcr_write: assert property (s_wr(16'h9c02, 1'b1)
		|=> fifo_ctrl_load && fifo_ctrl == $past(hwdata[7:0]))
		else $error("fifo control write lost");
	chk_div_read: assert property (s_rd(16'h9c08) |-> ##1 !hreadyout
		##1 hreadyout && hrdata == {24'h0, $past(divisor[7:0])})
		else $error("direct divisor low read wrong");
endmodule
bind urd_uart_regs urd_uart_regs_checker chk (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .tx_holding, .tx_load, .divisor, .irq_enable, .line_ctrl,
	.fifo_ctrl, .fifo_ctrl_load);

/* sim/urd_uart_regs_tb.sv */
`timescale 1ns/1ps
module urd_uart_regs_tb;
	logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, rx_valid, tx_taken, tx_idle;
	logic tx_load, fifo_ctrl_load, irq_pending, div_access;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] rx_data, tx_holding, irq_enable, line_ctrl, modem_ctrl, fifo_ctrl;
	logic [7:0] ier_m, tx_m, lo, hi;
	logic [15:0] divisor, power_emu_ctrl, div_m;
	int miscompares, checked;
	assign hready = hreadyout;
	urd_uart_regs uut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .rx_data, .rx_valid, .tx_taken, .tx_idle, .tx_holding,
		.tx_load, .divisor, .irq_enable, .line_ctrl, .modem_ctrl, .fifo_ctrl, .fifo_ctrl_load,
		.power_emu_ctrl, .irq_pending);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] sel(input logic f, input logic [7:0] a, input logic [7:0] b);
		return {24'h0, f ? a : b};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, $urandom);
		chk(rd, exp);
	endtask
	task automatic end_of_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test;
	end
	initial begin
		{nrst, hsel, hwrite, rx_valid, tx_taken, htrans, haddr, hwdata, rx_data} = '0;
		tx_idle = 1'b1;
		hsize = 3'h2;
		miscompares = 0;
		checked = 0;
		lo = 8'($urandom(32'h21ad));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rdc(16'h9c01, 32'h00);
		rdc(16'h9c02, 32'h01);
		rdc(16'h9c03, 32'h00);
		rdc(16'h9c05, 32'h60);
		rdc(16'h9c06, 32'h00);
		bus(1'b1, 16'h9c00, 32'ha5);
		@(posedge clk);
		chk({24'h0, tx_holding}, 32'ha5);
		chk({31'h0, tx_load}, 32'h1);
		rdc(16'h9c05, 32'h00);
		tx_taken <= 1'b1;
		rx_data <= 8'h3c;
		rx_valid <= 1'b1;
		@(posedge clk);
		tx_taken <= 1'b0;
		rx_valid <= 1'b0;
		rdc(16'h9c05, 32'h61);
		rdc(16'h9c00, 32'h3c);
		rdc(16'h9c05, 32'h60);
		div_m = 16'h0;
		ier_m = 8'h00;
		tx_m = 8'ha5;
		repeat (24) begin
			div_access = 1'($urandom_range(1));
			lo = 8'($urandom);
			hi = 8'($urandom);
			bus(1'b1, 16'h9c03, {24'h0, div_access, 7'h03});
			bus(1'b1, 16'h9c00, {24'h0, lo});
			bus(1'b1, 16'h9c01, {24'h0, hi});
			if (div_access) div_m = {hi, lo};
			else begin
				tx_m = lo;
				ier_m = hi;
			end
			@(posedge clk);
			chk({24'h0, line_ctrl}, {24'h0, div_access, 7'h03});
			chk({24'h0, tx_holding}, {24'h0, tx_m});
			chk({24'h0, irq_enable}, {24'h0, ier_m});
			rdc(16'h9c08, {24'h0, div_m[7:0]});
			rdc(16'h9c01, sel(div_access, div_m[15:8], ier_m));
			div_m = 16'($urandom);
			bus(1'b1, 16'h9c08, {24'h0, div_m[7:0]});
			bus(1'b1, 16'h9c09, {24'h0, div_m[15:8]});
			rdc(16'h9c00, sel(div_access, div_m[7:0], 8'h3c));
			chk({16'h0, divisor}, {16'h0, div_m});
		end
		bus(1'b1, 16'h9c03, 32'h0);
		bus(1'b1, 16'h9c01, 32'h0);
		bus(1'b1, 16'h9c02, 32'hc7);
		@(posedge clk);
		chk({31'h0, fifo_ctrl_load}, 32'h1);
		chk({24'h0, fifo_ctrl}, 32'hc7);
		rdc(16'h9c02, 32'h01);
		chk({31'h0, irq_pending}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, 16'h9c04, 32'h5a);
		bus(1'b1, 16'h9c07, 32'h96);
		bus(1'b1, 16'h9c06, 32'hff);
		hi = 8'($urandom);
		bus(1'b1, 16'h9c0c, {16'h0, hi, 8'he1});
		bus(1'b1, 16'h9c01, 32'h07);
		@(posedge clk);
		chk({24'h0, modem_ctrl}, 32'h5a);
		chk({16'h0, power_emu_ctrl}, {16'h0, hi, 8'he1});
		rdc(16'h9c07, 32'h96);
		rdc(16'h9c06, 32'h00);
		rdc(16'h9c0c, {16'h0, hi, 8'he1});
		rdc(16'h9c0a, {16'h0, urd_pkg::URD_PID_LOW_VALUE});
		rdc(16'h9c0b, {16'h0, urd_pkg::URD_PID_HIGH_VALUE});
		tx_taken <= 1'b1;
		@(posedge clk);
		tx_taken <= 1'b0;
		rdc(16'h9c02, {24'h0, urd_pkg::URD_IIR_TX});
		lo = 8'($urandom);
		rx_data <= 8'h11;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_data <= lo;
		@(posedge clk);
		rx_valid <= 1'b0;
		rdc(16'h9c02, {24'h0, urd_pkg::URD_IIR_LINE});
		chk({31'h0, irq_pending}, 32'h1);
		rdc(16'h9c05, 32'h63);
		rdc(16'h9c02, {24'h0, urd_pkg::URD_IIR_RX});
		rdc(16'h9c00, {24'h0, lo});
		rdc(16'h9c05, 32'h60);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({16'h0, divisor}, 32'h0);
		chk({24'h0, irq_enable}, 32'h0);
		chk({24'h0, modem_ctrl}, 32'h0);
		chk({16'h0, power_emu_ctrl}, 32'h0);
		rdc(16'h9c07, 32'h00);
		rdc(16'h9c05, {24'h0, urd_pkg::URD_RST_LSR});
		end_of_test;
	end
endmodule
